// ### hdl/cad_pkg.sv
// Shared constants, commands and state layout of the core datapath
package cad_pkg;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] OPB_RESET = 8'h00;
    localparam logic [7:0] SW_RESET = 8'h00;

    // ****************************************
    // Status word fields
    // ****************************************
    localparam int SW_CY = 7;
    localparam int SW_AC = 6;
    localparam int SW_OV = 2;
    localparam int SW_PAR = 0;

    // ****************************************
    // Decimal adjust constants
    // ****************************************
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [8:0] BCD_LO_ADJ = 9'h006;
    localparam logic [8:0] BCD_HI_ADJ = 9'h060;

    // ****************************************
    // Decoded commands
    // ****************************************
    typedef enum logic [5:0] {
        CMD_NOP, CMD_ADD, CMD_ADDC, CMD_SUBB, CMD_MUL, CMD_DIV, CMD_INC, CMD_DEC,
        CMD_DA, CMD_CMP, CMD_AND, CMD_OR, CMD_XOR, CMD_CPL, CMD_RR, CMD_RL,
        CMD_RRC, CMD_RLC, CMD_SWAP, CMD_MOVA, CMD_MOVB, CMD_BSET, CMD_BCLR,
        CMD_BCPL, CMD_JB, CMD_JNB, CMD_JBC, CMD_MOVCB, CMD_MOVBC, CMD_ANLC,
        CMD_ANLCN, CMD_ORLC, CMD_ORLCN, CMD_SETC, CMD_CLRC, CMD_CPLC, CMD_JC,
        CMD_JNC, CMD_JZ, CMD_JNZ, CMD_JEV, CMD_JMP
    } cad_cmd_e;

    // ****************************************
    // Arithmetic/logic operations
    // ****************************************
    typedef enum logic [4:0] {
        ALU_PASS, ALU_ADD, ALU_ADDC, ALU_SUBB, ALU_MUL, ALU_DIV, ALU_INC, ALU_DEC,
        ALU_DA, ALU_AND, ALU_OR, ALU_XOR, ALU_CPL, ALU_RR, ALU_RL, ALU_RRC,
        ALU_RLC, ALU_SWAP
    } cad_alu_e;

    // ****************************************
    // Core state
    // ****************************************
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] acc;
        logic [7:0] opb;
        logic [7:0] sw;
        logic bit_we;
        logic bit_wd;
        logic done;
    } cad_state_s;

endpackage

// ### hdl/cad_alu.sv
// Combinational arithmetic/logic unit
`timescale 1ns/10ps
module cad_alu (
    // Operation and operands
    input wire cad_pkg::cad_alu_e op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic cy_i,
    input wire logic ac_i,
    // Results and flags
    output logic [7:0] res_o,
    output logic [7:0] hi_o,
    output logic cy_o,
    output logic ac_o,
    output logic ov_o
);

    always_comb begin
        logic [8:0] sum;
        logic [4:0] nib;
        logic [15:0] prod;
        logic [8:0] da;
        logic cin;
        sum = '0;
        nib = '0;
        prod = '0;
        da = '0;
        cin = 1'b0;
        res_o = a_i;
        hi_o = b_i;
        cy_o = cy_i;
        ac_o = ac_i;
        ov_o = 1'b0;
        case (op_i)
            cad_pkg::ALU_ADD, cad_pkg::ALU_ADDC: begin
                cin = (op_i == cad_pkg::ALU_ADDC) ? cy_i : 1'b0;
                sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
                nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
                res_o = sum[7:0];
                cy_o = sum[8];
                ac_o = nib[4];
                ov_o = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
            end
            cad_pkg::ALU_SUBB: begin
                sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cy_i};
                nib = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cy_i};
                res_o = sum[7:0];
                cy_o = sum[8];
                ac_o = nib[4];
                ov_o = (a_i[7] != b_i[7]) && (sum[7] != a_i[7]);
            end
            cad_pkg::ALU_MUL: begin
                prod = {8'h00, a_i} * {8'h00, b_i};
                res_o = prod[7:0];
                hi_o = prod[15:8];
                cy_o = 1'b0;
                ov_o = |prod[15:8];
            end
            cad_pkg::ALU_DIV: begin
                cy_o = 1'b0;
                if (b_i == 8'h00) begin
                    ov_o = 1'b1;
                end else begin
                    res_o = a_i / b_i;
                    hi_o = a_i % b_i;
                end
            end
            cad_pkg::ALU_INC: res_o = a_i + 8'h01;
            cad_pkg::ALU_DEC: res_o = a_i - 8'h01;
            cad_pkg::ALU_DA: begin
                da = {1'b0, a_i};
                if ((a_i[3:0] > cad_pkg::BCD_MAX) || ac_i) begin
                    da = da + cad_pkg::BCD_LO_ADJ;
                end
                if ((da[7:4] > cad_pkg::BCD_MAX) || cy_i || da[8]) begin
                    da = da + cad_pkg::BCD_HI_ADJ;
                end
                res_o = da[7:0];
                cy_o = cy_i | da[8];
            end
            cad_pkg::ALU_AND: res_o = a_i & b_i;
            cad_pkg::ALU_OR: res_o = a_i | b_i;
            cad_pkg::ALU_XOR: res_o = a_i ^ b_i;
            cad_pkg::ALU_CPL: res_o = ~a_i;
            cad_pkg::ALU_RR: res_o = {a_i[0], a_i[7:1]};
            cad_pkg::ALU_RL: res_o = {a_i[6:0], a_i[7]};
            cad_pkg::ALU_RRC: begin
                res_o = {cy_i, a_i[7:1]};
                cy_o = a_i[0];
            end
            cad_pkg::ALU_RLC: begin
                res_o = {a_i[6:0], cy_i};
                cy_o = a_i[7];
            end
            cad_pkg::ALU_SWAP: res_o = {a_i[3:0], a_i[7:4]};
            cad_pkg::ALU_PASS: res_o = b_i;
            default: res_o = a_i;
        endcase
    end

endmodule

// ### hdl/cad_core.sv
// Core arithmetic datapath with decoder, status word and program counter
// Functional notes
// - The ALU combines one or two 8-bit operands into an 8-bit result, plus a high byte for multiply and divide, chosen by the decoder.
// - Add, subtract, multiply, divide, increment, decrement, decimal adjust and compare exist.
// - AND, OR, XOR, complement, rotate right, rotate left and nibble swap exist.
// - Bit ops set, clear, complement, branch on set, clear, set-and-clear, and move via carry.
// - Carry is ANDed or ORed with a bit or its inverse and the outcome kept in carry.
// - A 16-bit program counter holds the address of the next instruction.
// - Branch conditions from inside or outside the core change the next counter value.
// - The decoder turns each command into controls for data source, destination and ALU.
// - Accumulator, second operand register and status word hold operands and flags.
`timescale 1ns/10ps
module cad_core (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Instruction from fetch logic
    input wire logic instr_valid_i,
    input wire cad_pkg::cad_cmd_e cmd_i,
    input wire logic use_opb_i,
    input wire logic [7:0] imm_i,
    input wire logic [7:0] rel_i,
    // Addressed bit and external event
    input wire logic bit_i,
    input wire logic event_i,
    // Core state
    output logic [15:0] pc_o,
    output logic [7:0] acc_o,
    output logic [7:0] opb_o,
    output logic [7:0] status_word_o,
    // Bit write back and completion
    output logic bit_we_o,
    output logic bit_wd_o,
    output logic done_o
);

    // ****************************************
    // Declarations
    // ****************************************
    cad_pkg::cad_state_s st_q;
    cad_pkg::cad_state_s st_d;
    cad_pkg::cad_alu_e c_alu;
    logic [7:0] opnd;
    logic [15:0] rel_ext;
    logic cy;
    logic c_cin;
    logic c_acc_we;
    logic c_opb_we;
    logic c_opb_imm;
    logic c_acy_we;
    logic c_aac_we;
    logic c_aov_we;
    logic c_cy_we;
    logic c_cy_val;
    logic c_bit_we;
    logic c_bit_wd;
    logic c_branch;
    logic [7:0] alu_res;
    logic [7:0] alu_hi;
    logic alu_cy;
    logic alu_ac;
    logic alu_ov;

    assign cy = st_q.sw[cad_pkg::SW_CY];
    assign opnd = use_opb_i ? st_q.opb : imm_i;
    assign rel_ext = {{8{rel_i[7]}}, rel_i};

    // ****************************************
    // Instruction decoder
    // ****************************************
    always_comb begin
        c_alu = cad_pkg::ALU_PASS;
        c_cin = cy;
        c_acc_we = 1'b0;
        c_opb_we = 1'b0;
        c_opb_imm = 1'b0;
        c_acy_we = 1'b0;
        c_aac_we = 1'b0;
        c_aov_we = 1'b0;
        c_cy_we = 1'b0;
        c_cy_val = cy;
        c_bit_we = 1'b0;
        c_bit_wd = 1'b0;
        c_branch = 1'b0;
        if (instr_valid_i) begin
            case (cmd_i)
                cad_pkg::CMD_ADD, cad_pkg::CMD_ADDC, cad_pkg::CMD_SUBB: begin
                    c_alu = (cmd_i == cad_pkg::CMD_ADD) ? cad_pkg::ALU_ADD :
                            (cmd_i == cad_pkg::CMD_ADDC) ? cad_pkg::ALU_ADDC : cad_pkg::ALU_SUBB;
                    c_acc_we = 1'b1;
                    c_acy_we = 1'b1;
                    c_aac_we = 1'b1;
                    c_aov_we = 1'b1;
                end
                cad_pkg::CMD_MUL, cad_pkg::CMD_DIV: begin
                    c_alu = (cmd_i == cad_pkg::CMD_MUL) ? cad_pkg::ALU_MUL : cad_pkg::ALU_DIV;
                    c_acc_we = 1'b1;
                    c_opb_we = (cmd_i == cad_pkg::CMD_MUL) || (opnd != 8'h00);
                    c_acy_we = 1'b1;
                    c_aov_we = 1'b1;
                end
                cad_pkg::CMD_INC: begin
                    c_alu = cad_pkg::ALU_INC;
                    c_acc_we = 1'b1;
                end
                cad_pkg::CMD_DEC: begin
                    c_alu = cad_pkg::ALU_DEC;
                    c_acc_we = 1'b1;
                end
                cad_pkg::CMD_DA: begin
                    c_alu = cad_pkg::ALU_DA;
                    c_acc_we = 1'b1;
                    c_acy_we = 1'b1;
                end
                cad_pkg::CMD_CMP: begin
                    c_alu = cad_pkg::ALU_SUBB;
                    c_cin = 1'b0;
                    c_acy_we = 1'b1;
                    c_branch = (st_q.acc != opnd);
                end
                cad_pkg::CMD_AND: begin
                    c_alu = cad_pkg::ALU_AND;
                    c_acc_we = 1'b1;
                end
                cad_pkg::CMD_OR: begin
                    c_alu = cad_pkg::ALU_OR;
                    c_acc_we = 1'b1;
                end
                cad_pkg::CMD_XOR: begin
                    c_alu = cad_pkg::ALU_XOR;
                    c_acc_we = 1'b1;
                end
                cad_pkg::CMD_CPL: begin
                    c_alu = cad_pkg::ALU_CPL;
                    c_acc_we = 1'b1;
                end
                cad_pkg::CMD_RR: begin
                    c_alu = cad_pkg::ALU_RR;
                    c_acc_we = 1'b1;
                end
                cad_pkg::CMD_RL: begin
                    c_alu = cad_pkg::ALU_RL;
                    c_acc_we = 1'b1;
                end
                cad_pkg::CMD_RRC, cad_pkg::CMD_RLC: begin
                    c_alu = (cmd_i == cad_pkg::CMD_RRC) ? cad_pkg::ALU_RRC : cad_pkg::ALU_RLC;
                    c_acc_we = 1'b1;
                    c_acy_we = 1'b1;
                end
                cad_pkg::CMD_SWAP: begin
                    c_alu = cad_pkg::ALU_SWAP;
                    c_acc_we = 1'b1;
                end
                cad_pkg::CMD_MOVA: c_acc_we = 1'b1;
                cad_pkg::CMD_MOVB: begin
                    c_opb_we = 1'b1;
                    c_opb_imm = 1'b1;
                end
                cad_pkg::CMD_BSET: begin
                    c_bit_we = 1'b1;
                    c_bit_wd = 1'b1;
                end
                cad_pkg::CMD_BCLR: c_bit_we = 1'b1;
                cad_pkg::CMD_BCPL: begin
                    c_bit_we = 1'b1;
                    c_bit_wd = ~bit_i;
                end
                cad_pkg::CMD_JB: c_branch = bit_i;
                cad_pkg::CMD_JNB: c_branch = ~bit_i;
                cad_pkg::CMD_JBC: begin
                    c_branch = bit_i;
                    c_bit_we = bit_i;
                end
                cad_pkg::CMD_MOVCB: begin
                    c_cy_we = 1'b1;
                    c_cy_val = bit_i;
                end
                cad_pkg::CMD_MOVBC: begin
                    c_bit_we = 1'b1;
                    c_bit_wd = cy;
                end
                cad_pkg::CMD_ANLC, cad_pkg::CMD_ANLCN: begin
                    c_cy_we = 1'b1;
                    c_cy_val = cy & (bit_i ^ (cmd_i == cad_pkg::CMD_ANLCN));
                end
                cad_pkg::CMD_ORLC, cad_pkg::CMD_ORLCN: begin
                    c_cy_we = 1'b1;
                    c_cy_val = cy | (bit_i ^ (cmd_i == cad_pkg::CMD_ORLCN));
                end
                cad_pkg::CMD_SETC: begin
                    c_cy_we = 1'b1;
                    c_cy_val = 1'b1;
                end
                cad_pkg::CMD_CLRC: begin
                    c_cy_we = 1'b1;
                    c_cy_val = 1'b0;
                end
                cad_pkg::CMD_CPLC: begin
                    c_cy_we = 1'b1;
                    c_cy_val = ~cy;
                end
                cad_pkg::CMD_JC: c_branch = cy;
                cad_pkg::CMD_JNC: c_branch = ~cy;
                cad_pkg::CMD_JZ: c_branch = (st_q.acc == 8'h00);
                cad_pkg::CMD_JNZ: c_branch = (st_q.acc != 8'h00);
                cad_pkg::CMD_JEV: c_branch = event_i;
                cad_pkg::CMD_JMP: c_branch = 1'b1;
                default: c_branch = 1'b0;
            endcase
        end
    end

    // ****************************************
    // Arithmetic/logic unit
    // ****************************************
    cad_alu u_alu (
        .op_i(c_alu),
        .a_i(st_q.acc),
        .b_i(opnd),
        .cy_i(c_cin),
        .ac_i(st_q.sw[cad_pkg::SW_AC]),
        .res_o(alu_res),
        .hi_o(alu_hi),
        .cy_o(alu_cy),
        .ac_o(alu_ac),
        .ov_o(alu_ov)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        st_d.bit_we = c_bit_we;
        st_d.bit_wd = c_bit_wd;
        st_d.done = instr_valid_i;
        if (instr_valid_i) begin
            if (c_acc_we) begin
                st_d.acc = alu_res;
            end
            if (c_opb_we) begin
                st_d.opb = c_opb_imm ? opnd : alu_hi;
            end
            if (c_acy_we) begin
                st_d.sw[cad_pkg::SW_CY] = alu_cy;
            end
            if (c_aac_we) begin
                st_d.sw[cad_pkg::SW_AC] = alu_ac;
            end
            if (c_aov_we) begin
                st_d.sw[cad_pkg::SW_OV] = alu_ov;
            end
            if (c_cy_we) begin
                st_d.sw[cad_pkg::SW_CY] = c_cy_val;
            end
            st_d.pc = c_branch ? st_q.pc + cad_pkg::PC_STEP + rel_ext :
                      st_q.pc + cad_pkg::PC_STEP;
        end
        st_d.sw[cad_pkg::SW_PAR] = ^st_d.acc;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '{pc: cad_pkg::PC_RESET, acc: cad_pkg::ACC_RESET, opb: cad_pkg::OPB_RESET,
                      sw: cad_pkg::SW_RESET, bit_we: 1'b0, bit_wd: 1'b0, done: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign pc_o = st_q.pc;
    assign acc_o = st_q.acc;
    assign opb_o = st_q.opb;
    assign status_word_o = st_q.sw;
    assign bit_we_o = st_q.bit_we;
    assign bit_wd_o = st_q.bit_wd;
    assign done_o = st_q.done;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    pc_step_a: assert property (instr_valid_i && !c_branch |=> pc_o == $past(pc_o) + 16'h0001)
        else $error("pc did not step");
    pc_hold_a: assert property (!instr_valid_i |=> $stable(pc_o) && !done_o)
        else $error("pc moved without instruction");
    pc_branch_a: assert property (instr_valid_i && c_branch |=>
        pc_o == $past(pc_o) + 16'h0001 + $past(rel_ext))
        else $error("branch target wrong");
    add_res_a: assert property (instr_valid_i && cmd_i == cad_pkg::CMD_ADD |=>
        acc_o == 8'($past(acc_o) + $past(opnd)))
        else $error("add result wrong");
    inc_wrap_a: assert property (instr_valid_i && cmd_i == cad_pkg::CMD_INC |=>
        acc_o == 8'($past(acc_o) + 8'h01))
        else $error("increment wrong");
    swap_nib_a: assert property (instr_valid_i && cmd_i == cad_pkg::CMD_SWAP |=>
        acc_o == {$past(acc_o[3:0]), $past(acc_o[7:4])})
        else $error("swap wrong");
    mul_prod_a: assert property (instr_valid_i && cmd_i == cad_pkg::CMD_MUL |=>
        {opb_o, acc_o} == 16'($past(acc_o)) * 16'($past(opnd)))
        else $error("product wrong");
    div_quot_a: assert property (instr_valid_i && cmd_i == cad_pkg::CMD_DIV && opnd != 8'h00
        |=> acc_o == $past(acc_o) / $past(opnd) && opb_o == $past(acc_o) % $past(opnd))
        else $error("division wrong");
    jbc_clear_a: assert property (instr_valid_i && cmd_i == cad_pkg::CMD_JBC && bit_i |=>
        bit_we_o && !bit_wd_o ##1 (!bit_we_o || $past(instr_valid_i)))
        else $error("jump-and-clear did not clear bit");
    anl_carry_a: assert property (instr_valid_i && cmd_i == cad_pkg::CMD_ANLC |=>
        status_word_o[cad_pkg::SW_CY] == ($past(status_word_o[cad_pkg::SW_CY]) && $past(bit_i)))
        else $error("carry and wrong");
    cmp_keep_a: assert property (instr_valid_i && cmd_i == cad_pkg::CMD_CMP |=>
        $stable(acc_o) && !bit_we_o)
        else $error("compare disturbed accumulator");
    parity_a: assert property (status_word_o[0] == ^acc_o)
        else $error("parity flag wrong");

    mul_c: cover property (instr_valid_i && cmd_i == cad_pkg::CMD_MUL ##1 opb_o != 8'h00);
    da_c: cover property (instr_valid_i && cmd_i == cad_pkg::CMD_DA ##1 status_word_o[7]);
    jbc_c: cover property (instr_valid_i && cmd_i == cad_pkg::CMD_JBC && bit_i);
    branch_c: cover property (instr_valid_i && c_branch ##1 instr_valid_i && c_branch);

endmodule

// ### test/cad_fetch_model.sv
// Behavioural fetch and decode partner with the addressed bit store
`timescale 1ns/10ps
module cad_fetch_model (
    // Clock and bit write back from the core
    input wire logic clock_i,
    input wire logic bit_we_i,
    input wire logic bit_wd_i,
    // Instruction to the core
    output logic instr_valid_o,
    output cad_pkg::cad_cmd_e cmd_o,
    output logic use_opb_o,
    output logic [7:0] imm_o,
    output logic [7:0] rel_o,
    output logic event_o,
    // Addressed bit
    output logic bit_o
);
    logic bit_q;

    initial begin
        instr_valid_o = 1'h0;
        cmd_o = cad_pkg::CMD_NOP;
        use_opb_o = 1'h0;
        imm_o = 8'h00;
        rel_o = 8'h00;
        event_o = 1'h0;
        bit_q = 1'h0;
    end

    // Bit store, written by the core, write visible at once
    always @(posedge clock_i) begin
        if (bit_we_i) begin
            bit_q <= bit_wd_i;
        end
    end
    assign bit_o = bit_we_i ? bit_wd_i : bit_q;

    // Present one instruction for the next rising edge
    task automatic issue(input cad_pkg::cad_cmd_e c, input logic ub, input logic [7:0] im,
                         input logic [7:0] rl, input logic ev);
        instr_valid_o = 1'h1;
        cmd_o = c;
        use_opb_o = ub;
        imm_o = im;
        rel_o = rl;
        event_o = ev;
    endtask

    // No instruction, operands scrambled
    task automatic idle();
        instr_valid_o = 1'h0;
        use_opb_o = ~use_opb_o;
        imm_o = ~imm_o;
        rel_o = ~rel_o;
        event_o = ~event_o;
    endtask
endmodule

// ### test/testbench.sv
// Self-checking testbench of the core datapath
`timescale 1ns/10ps
module testbench;
    logic clock_i, rst_i, instr_valid_i, use_opb_i, bit_i, event_i;
    cad_pkg::cad_cmd_e cmd_i;
    logic [7:0] imm_i, rel_i, acc_o, opb_o, status_word_o, e_a, e_b;
    logic [15:0] pc_o, e_pc, lf, r;
    logic bit_we_o, bit_wd_o, done_o, e_cy, e_ac, e_ov, e_we, e_wd, e_bit;
    int mismatches, checks_done;
    logic [23:0] corner [19] = '{24'h13FF00, 24'h14FF00, 24'h840000, 24'h050000, 24'h13FF00,
        24'h050700, 24'h133800, 24'h012900, 24'h080000, 24'h139900, 24'h019900, 24'h080000,
        24'h030100, 24'h150000, 24'h1A0080, 24'h1A0080, 24'h290080, 24'h29007F, 24'h000000};

    cad_core i_dut (.clock_i(clock_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .cmd_i(cmd_i), .use_opb_i(use_opb_i), .imm_i(imm_i), .rel_i(rel_i), .bit_i(bit_i),
        .event_i(event_i), .pc_o(pc_o), .acc_o(acc_o), .opb_o(opb_o),
        .status_word_o(status_word_o), .bit_we_o(bit_we_o), .bit_wd_o(bit_wd_o),
        .done_o(done_o));
    cad_fetch_model i_fetch (.clock_i(clock_i), .bit_we_i(bit_we_o), .bit_wd_i(bit_wd_o),
        .instr_valid_o(instr_valid_i), .cmd_o(cmd_i), .use_opb_o(use_opb_i), .imm_o(imm_i),
        .rel_o(rel_i), .event_o(event_i), .bit_o(bit_i));

    always #2 clock_i = ~clock_i;

    // ****************************************
    // Checking and prediction
    // ****************************************
    task automatic complete_run();
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s at %0t: got %b expected %b", what, $time, got, exp);
        end
    endtask

    task automatic check_state(input logic d);
        chk_v(pc_o, e_pc, "pc");
        chk_v(acc_o, e_a, "acc");
        chk_v(opb_o, e_b, "opb");
        chk_v(status_word_o, {e_cy, e_ac, 3'h0, e_ov, 1'h0, ^e_a}, "flags");
        chk_b(bit_we_o, e_we, "bit write");
        if (e_we) chk_b(bit_wd_o, e_wd, "bit value");
        chk_b(done_o, d, "done");
    endtask

    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        for (int k = 0; k < 16; k++) v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
        return v;
    endfunction

    task automatic predict(input cad_pkg::cad_cmd_e c, input logic ub, input logic [7:0] im,
                           input logic [7:0] rl, input logic ev);
        logic [7:0] o, x;
        logic [8:0] s;
        logic [4:0] h;
        logic [15:0] p;
        logic br, sb, ci, nc;
        o = ub ? e_b : im;
        br = 1'h0;
        e_we = 1'h0;
        e_wd = 1'h0;
        case (c)
            cad_pkg::CMD_ADD, cad_pkg::CMD_ADDC, cad_pkg::CMD_SUBB: begin
                sb = (c == cad_pkg::CMD_SUBB);
                x = sb ? ~o : o;
                ci = sb ? ~e_cy : (c == cad_pkg::CMD_ADDC) & e_cy;
                s = e_a + x + ci;
                h = e_a[3:0] + x[3:0] + ci;
                e_ov = (e_a[7] == x[7]) && (s[7] != e_a[7]);
                e_cy = s[8] ^ sb;
                e_ac = h[4] ^ sb;
                e_a = s[7:0];
            end
            cad_pkg::CMD_MUL: begin
                p = e_a * o;
                {e_b, e_a} = p;
                e_cy = 1'h0;
                e_ov = |p[15:8];
            end
            cad_pkg::CMD_DIV: begin
                e_cy = 1'h0;
                e_ov = (o == 8'h00);
                if (o != 8'h00) {e_a, e_b} = {e_a / o, e_a % o};
            end
            cad_pkg::CMD_INC: e_a = e_a + 8'h01;
            cad_pkg::CMD_DEC: e_a = e_a - 8'h01;
            cad_pkg::CMD_DA: begin
                s = {1'h0, e_a};
                if (e_a[3:0] > 4'h9 || e_ac) s = s + 9'h006;
                if (s[7:4] > 4'h9 || s[8] || e_cy) s = s + 9'h060;
                e_cy = e_cy | s[8];
                e_a = s[7:0];
            end
            cad_pkg::CMD_CMP: {e_cy, br} = {e_a < o, e_a != o};
            cad_pkg::CMD_AND: e_a = e_a & o;
            cad_pkg::CMD_OR: e_a = e_a | o;
            cad_pkg::CMD_XOR: e_a = e_a ^ o;
            cad_pkg::CMD_CPL: e_a = ~e_a;
            cad_pkg::CMD_RR: e_a = {e_a[0], e_a[7:1]};
            cad_pkg::CMD_RL: e_a = {e_a[6:0], e_a[7]};
            cad_pkg::CMD_RRC: {e_a, e_cy} = {e_cy, e_a};
            cad_pkg::CMD_RLC: {e_cy, e_a} = {e_a, e_cy};
            cad_pkg::CMD_SWAP: e_a = {e_a[3:0], e_a[7:4]};
            cad_pkg::CMD_MOVA: e_a = o;
            cad_pkg::CMD_MOVB: e_b = o;
            cad_pkg::CMD_BSET: {e_we, e_wd} = 2'h3;
            cad_pkg::CMD_BCLR: {e_we, e_wd} = 2'h2;
            cad_pkg::CMD_BCPL: {e_we, e_wd} = {1'h1, ~e_bit};
            cad_pkg::CMD_JB: br = e_bit;
            cad_pkg::CMD_JNB: br = ~e_bit;
            cad_pkg::CMD_JBC: {br, e_we} = {e_bit, e_bit};
            cad_pkg::CMD_MOVCB: e_cy = e_bit;
            cad_pkg::CMD_MOVBC: {e_we, e_wd} = {1'h1, e_cy};
            cad_pkg::CMD_ANLC: e_cy = e_cy & e_bit;
            cad_pkg::CMD_ANLCN: e_cy = e_cy & ~e_bit;
            cad_pkg::CMD_ORLC: e_cy = e_cy | e_bit;
            cad_pkg::CMD_ORLCN: e_cy = e_cy | ~e_bit;
            cad_pkg::CMD_SETC: e_cy = 1'h1;
            cad_pkg::CMD_CLRC: e_cy = 1'h0;
            cad_pkg::CMD_CPLC: e_cy = ~e_cy;
            cad_pkg::CMD_JC: br = e_cy;
            cad_pkg::CMD_JNC: br = ~e_cy;
            cad_pkg::CMD_JZ: br = (e_a == 8'h00);
            cad_pkg::CMD_JNZ: br = (e_a != 8'h00);
            cad_pkg::CMD_JEV: br = ev;
            cad_pkg::CMD_JMP: br = 1'h1;
            default: br = 1'h0;
        endcase
        nc = e_we;
        if (nc) e_bit = e_wd;
        e_pc = e_pc + 16'h0001 + (br ? {{8{rl[7]}}, rl} : 16'h0000);
    endtask

    // ****************************************
    // Stimulus
    // ****************************************
    task automatic run_one(input cad_pkg::cad_cmd_e c, input logic ub, input logic [7:0] im,
                           input logic [7:0] rl, input logic ev);
        i_fetch.issue(c, ub, im, rl, ev);
        predict(c, ub, im, rl, ev);
        @(posedge clock_i);
        @(negedge clock_i);
        check_state(1'h1);
    endtask

    task automatic idle_one();
        i_fetch.idle();
        e_we = 1'h0;
        @(posedge clock_i);
        @(negedge clock_i);
        check_state(1'h0);
    endtask

    task automatic do_reset();
        i_fetch.idle();
        if (e_we === 1'h1) @(negedge clock_i);
        rst_i = 1'h1;
        repeat (2) @(negedge clock_i);
        rst_i = 1'h0;
        {e_pc, e_a, e_b, e_cy, e_ac, e_ov, e_we} = {16'h0000, 8'h00, 8'h00, 4'h0};
        check_state(1'h0);
    endtask

    initial begin
        clock_i = 1'h0;
        rst_i = 1'h1;
        mismatches = 0;
        checks_done = 0;
        lf = 16'hD5A3;
        e_bit = 1'h0;
        do_reset();
        for (int i = 0; i < 42; i++) run_one(cad_pkg::cad_cmd_e'(6'(i)), i[0], 8'(i * 37),
            8'(i * 11), i[1]);
        foreach (corner[i]) run_one(cad_pkg::cad_cmd_e'(corner[i][21:16]), corner[i][23],
            corner[i][15:8], corner[i][7:0], 1'h1);
        for (int n = 0; n < 400; n++) begin
            lf = lfsr_step(lf);
            r = lf;
            lf = lfsr_step(lf);
            run_one(cad_pkg::cad_cmd_e'(6'(r[5:0] % 42)), r[6], r[15:8], lf[7:0], lf[8]);
            if (lf[9] & lf[10]) idle_one();
            if (n == 200) do_reset();
        end
        complete_run();
    end

    initial begin
        #8000;
        mismatches++;
        complete_run();
    end
endmodule
